// *** rtl/wbm_pkg.sv ***
// Shared constants and types of the word bit manipulation unit
package wbm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int WBM_WORD_W = 16;
  localparam int WBM_NIB_W = 4;
  localparam int WBM_SLOTS = 4;
  localparam int WBM_LOW_BYTE_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int WBM_DP_BIT = 7; // Decimal point bit kept by segment write
  localparam int WBM_SEG_W = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [15:0] WBM_WORD_RST = 16'h0000;
  localparam logic [3:0] WBM_EN_RST = 4'h0;
  localparam logic WBM_FLAG_RST = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Operation codes, one-hot
  typedef enum logic [8:0] {
    WBM_OP_PRIORITY_ENCODE = 9'h001,
    WBM_OP_ONE_HOT_DECODE = 9'h002,
    WBM_OP_NIBBLE_SPLIT = 9'h004,
    WBM_OP_NIBBLE_COMBINE = 9'h008,
    WBM_OP_BIT_FORCE_ONE = 9'h010,
    WBM_OP_BIT_FORCE_ZERO = 9'h020,
    WBM_OP_BIT_TOGGLE = 9'h040,
    WBM_OP_BIT_PROBE = 9'h080,
    WBM_OP_SEVEN_SEGMENT = 9'h100
  } wbm_op_t;

endpackage

// *** rtl/wbm_prio_enc.sv ***
`timescale 1ns/1ps
// Highest set bit finder: 0 when empty, else index plus one
module wbm_prio_enc
  import wbm_pkg::*;
(
  input wire logic [15:0] word_in,
  output logic [7:0] code_out
);

  // Scan upward so the highest set bit overwrites lower ones
  always_comb begin
    code_out = 8'h00;
    for (int i = 0; i < WBM_WORD_W; i++) begin
      if (word_in[i]) begin
        code_out = 8'(i + 1);
      end
    end
  end

endmodule

// *** rtl/wbm_seg_rom.sv ***
`timescale 1ns/1ps
// Hex digit to active-high segment pattern, bit 0 = segment a
module wbm_seg_rom
  import wbm_pkg::*;
(
  input wire logic [3:0] digit,
  output logic [6:0] segs
);

  // Constant pattern table
  always_comb begin
    case (digit)
      4'h0: segs = 7'h3F;
      4'h1: segs = 7'h06;
      4'h2: segs = 7'h5B;
      4'h3: segs = 7'h4F;
      4'h4: segs = 7'h66;
      4'h5: segs = 7'h6D;
      4'h6: segs = 7'h7D;
      4'h7: segs = 7'h07;
      4'h8: segs = 7'h7F;
      4'h9: segs = 7'h6F;
      4'hA: segs = 7'h77;
      4'hB: segs = 7'h7C;
      4'hC: segs = 7'h39;
      4'hD: segs = 7'h5E;
      4'hE: segs = 7'h79;
      4'hF: segs = 7'h71;
      default: segs = 7'h00;
    endcase
  end

endmodule

// *** rtl/wbm_core.sv ***
`timescale 1ns/1ps
module wbm_core
  import wbm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic exec_strobe,
  input wire logic [8:0] op_code,
  input wire logic [1:0] nibble_count,
  input wire logic [3:0] bit_index,
  input wire logic [15:0] source_operand,
  input wire logic [15:0] dest_word,
  input wire logic [15:0] combine_word0,
  input wire logic [15:0] combine_word1,
  input wire logic [15:0] combine_word2,
  input wire logic [15:0] combine_word3,
  output logic [15:0] wb_data0,
  output logic [15:0] wb_data1,
  output logic [15:0] wb_data2,
  output logic [15:0] wb_data3,
  output logic [3:0] wb_en,
  output logic carry_flag,
  output logic carry_we,
  output logic op_done,
  output logic op_error
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // One-hot word from a four-bit index
  function automatic logic [15:0] wbm_one_hot(input logic [3:0] idx);
    logic [15:0] v;
    v = 16'h0000;
    v[idx] = 1'b1;
    return v;
  endfunction

  // Slot enable mask for count plus one slots
  function automatic logic [3:0] wbm_slot_mask(input logic [1:0] cnt);
    logic [3:0] m;
    m = 4'h0;
    for (int i = 0; i < WBM_SLOTS; i++) begin
      m[i] = (2'(i) <= cnt);
    end
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flip-flops

  logic rst_meta_r;
  logic rst_sync_r;

  // Assert at once, release after two edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operation select

  wbm_op_t op;
  logic op_prio;
  logic op_dec;
  logic op_split;
  logic op_comb;
  logic op_set;
  logic op_clr;
  logic op_tog;
  logic op_probe;
  logic op_seg;
  logic op_known;

  // Code viewed as the operation type
  assign op = wbm_op_t'(op_code);

  // Individual operation qualifiers
  assign op_prio = (op == WBM_OP_PRIORITY_ENCODE);
  assign op_dec = (op == WBM_OP_ONE_HOT_DECODE);
  assign op_split = (op == WBM_OP_NIBBLE_SPLIT);
  assign op_comb = (op == WBM_OP_NIBBLE_COMBINE);
  assign op_set = (op == WBM_OP_BIT_FORCE_ONE);
  assign op_clr = (op == WBM_OP_BIT_FORCE_ZERO);
  assign op_tog = (op == WBM_OP_BIT_TOGGLE);
  assign op_probe = (op == WBM_OP_BIT_PROBE);
  assign op_seg = (op == WBM_OP_SEVEN_SEGMENT);

  // Any other code is refused with an error pulse
  assign op_known = op_prio | op_dec | op_split | op_comb | op_set
                  | op_clr | op_tog | op_probe | op_seg;

  ////////////////////////////////////////////////////////////////////////////
  // Priority encoder

  logic [7:0] prio_code;
  logic [15:0] prio_word;

  // Highest set bit wins, lower ones ignored
  wbm_prio_enc u_prio (
    .word_in(source_operand),
    .code_out(prio_code)
  );

  // Result to low byte, upper byte kept
  assign prio_word = {dest_word[15:WBM_LOW_BYTE_W], prio_code};

  ////////////////////////////////////////////////////////////////////////////
  // One-hot decoder

  logic [15:0] dec_word;

  // Only the indexed bit set
  assign dec_word = wbm_one_hot(source_operand[3:0]);

  ////////////////////////////////////////////////////////////////////////////
  // Nibble combine

  logic [15:0] comb_words [WBM_SLOTS];
  logic [15:0] comb_word;
  logic [3:0] slot_mask;

  // Consecutive source words in order
  assign comb_words[0] = combine_word0;
  assign comb_words[1] = combine_word1;
  assign comb_words[2] = combine_word2;
  assign comb_words[3] = combine_word3;

  // Count plus one slots in use
  assign slot_mask = wbm_slot_mask(nibble_count);

  // First word gives the lowest nibble; unused nibbles read zero
  generate
    for (genvar g = 0; g < WBM_SLOTS; g++) begin : g_comb
      assign comb_word[g*WBM_NIB_W +: WBM_NIB_W] =
        slot_mask[g] ? comb_words[g][3:0] : 4'h0;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Single-bit operations on the whole destination word

  logic [15:0] bit_mask;
  logic [15:0] set_word;
  logic [15:0] clr_word;
  logic [15:0] tog_word;
  logic probe_bit;

  // Read-modify-write of the full word
  assign bit_mask = wbm_one_hot(bit_index[3:0]);
  assign set_word = dest_word | bit_mask;
  assign clr_word = dest_word & ~bit_mask;
  assign tog_word = dest_word ^ bit_mask;

  // Probe reads the bit and writes nothing back
  assign probe_bit = |(dest_word & bit_mask);

  ////////////////////////////////////////////////////////////////////////////
  // Seven-segment conversion

  logic [6:0] seg_pattern;
  logic [15:0] seg_word;

  // Active-high pattern from source low nibble
  wbm_seg_rom u_seg (
    .digit(source_operand[3:0]),
    .segs(seg_pattern)
  );

  // Keep upper byte and decimal point, replace segments
  assign seg_word = {dest_word[15:WBM_DP_BIT], seg_pattern};

  ////////////////////////////////////////////////////////////////////////////
  // Single-slot result select

  logic [15:0] single_word;

  // Word written back to the destination for single-word ops
  assign single_word = op_prio ? prio_word :
                       op_dec ? dec_word :
                       op_comb ? comb_word :
                       op_set ? set_word :
                       op_clr ? clr_word :
                       op_tog ? tog_word :
                       op_seg ? seg_word : dest_word;

  ////////////////////////////////////////////////////////////////////////////
  // Write-back slots

  logic [15:0] slot_nxt [WBM_SLOTS];
  logic [15:0] slot_r [WBM_SLOTS];
  logic [3:0] en_nxt;
  logic [3:0] en_r;
  logic single_wr;

  // Ops that write only the destination word
  assign single_wr = op_prio | op_dec | op_comb | op_set | op_clr
                   | op_tog | op_seg;

  // Split fills count plus one slots, single-word ops take slot 0
  generate
    for (genvar s = 0; s < WBM_SLOTS; s++) begin : g_slot
      if (s == 0) begin : g_first
        assign slot_nxt[s] = op_split ?
          {12'h000, source_operand[3:0]} : single_word;
        assign en_nxt[s] = exec_strobe & ((op_split & slot_mask[s]) | single_wr);
      end else begin : g_rest
        assign slot_nxt[s] = op_split ?
          {12'h000, source_operand[s*WBM_NIB_W +: WBM_NIB_W]} : WBM_WORD_RST;
        assign en_nxt[s] = exec_strobe & op_split & slot_mask[s];
      end

      // Registered slot value
      always_ff @(posedge clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
          slot_r[s] <= WBM_WORD_RST;
        end else if (en_nxt[s]) begin
          slot_r[s] <= slot_nxt[s];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Strobe-qualified status

  logic carry_r;
  logic carry_we_r;
  logic done_r;
  logic err_r;
  logic carry_we_nxt;
  logic err_nxt;

  // Carry written only by the probe op
  assign carry_we_nxt = exec_strobe & op_probe;

  // Unknown codes flagged, nothing written
  assign err_nxt = exec_strobe & ~op_known;

  // Enables, done and error stand one cycle per strobe
  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      en_r <= WBM_EN_RST;
      carry_we_r <= WBM_FLAG_RST;
      done_r <= WBM_FLAG_RST;
      err_r <= WBM_FLAG_RST;
    end else begin
      en_r <= en_nxt;
      carry_we_r <= carry_we_nxt;
      done_r <= exec_strobe;
      err_r <= err_nxt;
    end
  end

  // Carry holds its last tested value
  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      carry_r <= WBM_FLAG_RST;
    end else if (carry_we_nxt) begin
      carry_r <= probe_bit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flip-flops

  assign wb_data0 = slot_r[0];
  assign wb_data1 = slot_r[1];
  assign wb_data2 = slot_r[2];
  assign wb_data3 = slot_r[3];

  // Status pulses and carry level
  assign wb_en = en_r;
  assign carry_flag = carry_r;
  assign carry_we = carry_we_r;
  assign op_done = done_r;
  assign op_error = err_r;

endmodule

// *** tb/wbm_core_assertions.sv ***
`timescale 1ns/1ps
module wbm_core_assertions
  import wbm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic exec_strobe,
  input wire logic [8:0] op_code,
  input wire logic [1:0] nibble_count,
  input wire logic [3:0] bit_index,
  input wire logic [15:0] source_operand,
  input wire logic [15:0] dest_word,
  input wire logic [15:0] wb_data0,
  input wire logic [3:0] wb_en,
  input wire logic carry_flag,
  input wire logic carry_we,
  input wire logic op_done
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////
  // Strobe taken with a given op
  sequence take(logic [8:0] op);
    exec_strobe && op_code == op;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  // Timing and function checks
  done_per_take_a: assert property (
    exec_strobe |=> op_done) else $error("done missing after strobe");
  done_cause_a: assert property (
    op_done |-> $past(exec_strobe)) else $error("done without strobe");
  encode_keep_a: assert property (
    take(WBM_OP_PRIORITY_ENCODE) |=> wb_en == 4'h1
    && (wb_data0 & 16'hFF00) == ($past(dest_word) & 16'hFF00))
    else $error("encode upper byte changed");
  decode_onehot_a: assert property (
    take(WBM_OP_ONE_HOT_DECODE)
    |=> wb_data0 == (16'h0001 << ($past(source_operand) & 16'h000F)))
    else $error("decode not one hot");
  split_slot_a: assert property (
    take(WBM_OP_NIBBLE_SPLIT) |=> wb_en == (4'hF >> (2'd3 - $past(nibble_count)))
    && wb_data0 == ($past(source_operand) & 16'h000F)) else $error("split slot wrong");
  bit_set_a: assert property (
    take(WBM_OP_BIT_FORCE_ONE)
    |=> wb_data0 == ($past(dest_word) | (16'h0001 << $past(bit_index))))
    else $error("bit set wrong");
  probe_carry_a: assert property (
    take(WBM_OP_BIT_PROBE) |=> carry_we && wb_en == 4'h0
    && carry_flag == 1'($past(dest_word) >> $past(bit_index)))
    else $error("probe carry wrong");
  carry_hold_a: assert property (
    !carry_we |-> $stable(carry_flag)) else $error("carry moved without probe");
  seg_keep_a: assert property (
    take(WBM_OP_SEVEN_SEGMENT)
    |=> (wb_data0 & 16'hFF80) == ($past(dest_word) & 16'hFF80))
    else $error("segment write touched kept bits");
endmodule

bind wbm_core wbm_core_assertions chk_i (.clk(clk), .rst_n(rst_n),
  .exec_strobe(exec_strobe), .op_code(op_code), .nibble_count(nibble_count),
  .bit_index(bit_index), .source_operand(source_operand), .dest_word(dest_word),
  .wb_data0(wb_data0), .wb_en(wb_en), .carry_flag(carry_flag), .carry_we(carry_we),
  .op_done(op_done));

// *** tb/wbm_seq_model.sv ***
`timescale 1ns/1ps
// Scan sequencer: issues one instruction, strobe held n scans
module wbm_seq_model (
  input wire logic clk,
  output logic exec_strobe,
  output logic [8:0] op_code,
  output logic [1:0] nibble_count,
  output logic [3:0] bit_index,
  output logic [15:0] source_operand,
  output logic [15:0] dest_word,
  output logic [63:0] cw
);
  initial begin
    exec_strobe = 1'b0;
    op_code = 9'h000;
    nibble_count = 2'd0;
    bit_index = 4'h0;
    source_operand = 16'h0000;
    dest_word = 16'h0000;
    cw = 64'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operands scrambled after the take edge so late sampling shows
  task automatic issue(logic [8:0] op, logic [1:0] c, logic [3:0] i, logic [15:0] s,
                       logic [15:0] d, logic [63:0] w, int n);
    @(posedge clk);
    exec_strobe <= 1'b1;
    op_code <= op;
    nibble_count <= c;
    bit_index <= i;
    source_operand <= s;
    dest_word <= d;
    cw <= w;
    repeat (n) @(posedge clk);
    exec_strobe <= 1'b0;
    source_operand <= ~s;
    dest_word <= ~d;
    cw <= ~w;
    #1;
  endtask
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb
  import wbm_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic exec_strobe;
  logic [8:0] op_code;
  logic [1:0] nibble_count;
  logic [3:0] bit_index;
  logic [15:0] source_operand, dest_word, wb_data0, wb_data1, wb_data2, wb_data3;
  logic [63:0] cw;
  logic [3:0] wb_en;
  logic carry_flag, carry_we, op_done, op_error;
  wire [63:0] wbd = {wb_data3, wb_data2, wb_data1, wb_data0};
  int fails = 0;
  int n_tests = 0;
  int n_done = 0;

  always #5 clk = ~clk;
  always @(posedge clk) if (op_done === 1'b1) n_done <= n_done + 1;

  wbm_seq_model seq (.clk(clk), .exec_strobe(exec_strobe), .op_code(op_code),
    .nibble_count(nibble_count), .bit_index(bit_index), .source_operand(source_operand),
    .dest_word(dest_word), .cw(cw));
  wbm_core uut (.clk(clk), .rst_n(rst_n), .exec_strobe(exec_strobe), .op_code(op_code),
    .nibble_count(nibble_count), .bit_index(bit_index), .source_operand(source_operand),
    .dest_word(dest_word), .combine_word0(cw[15:0]), .combine_word1(cw[31:16]),
    .combine_word2(cw[47:32]), .combine_word3(cw[63:48]), .wb_data0(wb_data0),
    .wb_data1(wb_data1), .wb_data2(wb_data2), .wb_data3(wb_data3), .wb_en(wb_en),
    .carry_flag(carry_flag), .carry_we(carry_we), .op_done(op_done), .op_error(op_error));

  ////////////////////////////////////////////////////////////////////////////
  // Compare, issue shortcut, verdict
  task chk(string name, logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task run(logic [8:0] op, logic [1:0] c, logic [3:0] i, logic [15:0] s, logic [15:0] d);
    seq.issue(op, c, i, s, d, 64'h7654_789A_456F_0123, 1);
  endtask
  task close_out;
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task t_encode;
    for (int i = 0; i <= 16; i++) begin
      run(WBM_OP_PRIORITY_ENCODE, 2'd0, 4'h0, (i == 0) ? 16'h0 : 16'hFFFF >> (16 - i), 16'hA5C3);
      chk("enc", wb_data0, {8'hA5, 8'(i)});
      chk("enc_en", {12'h000, wb_en}, 16'h0001);
    end
  endtask
  task t_decode;
    for (int i = 0; i < 16; i++) begin
      run(WBM_OP_ONE_HOT_DECODE, 2'd0, 4'h0, {12'hB7E, 4'(i)}, 16'hFFFF);
      chk("dec", wb_data0, 16'h0001 << i);
    end
  endtask
  task t_split;
    for (int c = 0; c < 4; c++) begin
      run(WBM_OP_NIBBLE_SPLIT, 2'(c), 4'h0, 16'h74E5, 16'h1111);
      chk("spl_en", {12'h000, wb_en}, {12'h000, 4'hF >> (3 - c)});
      for (int k = 0; k <= c; k++)
        chk("spl", wbd[16*k +: 16], {12'h000, 4'(16'h74E5 >> (4 * k))});
    end
  endtask
  task t_combine;
    logic [15:0] e;
    for (int c = 0; c < 4; c++) begin
      e = 16'h0;
      for (int k = 0; k <= c; k++) e[4*k +: 4] = 4'(64'h7654_789A_456F_0123 >> (16 * k));
      run(WBM_OP_NIBBLE_COMBINE, 2'(c), 4'h0, 16'h0, 16'hABCD);
      chk("uni", wb_data0, e);
    end
  endtask
  task t_bits;
    logic [15:0] m;
    for (int n = 0; n < 16; n += 5) begin
      m = 16'h0001 << n;
      run(WBM_OP_BIT_FORCE_ONE, 2'd0, 4'(n), 16'h0, 16'h5A3C);
      chk("set", wb_data0, 16'h5A3C | m);
      run(WBM_OP_BIT_FORCE_ZERO, 2'd0, 4'(n), 16'h0, 16'h5A3C);
      chk("clr", wb_data0, 16'h5A3C & ~m);
      run(WBM_OP_BIT_TOGGLE, 2'd0, 4'(n), 16'h0, 16'h5A3C);
      chk("tgl", wb_data0, 16'h5A3C ^ m);
    end
    for (int n = 0; n < 16; n += 3) begin
      m = 16'h8000 | ((16'h7874 >> n) & 16'h0001);
      run(WBM_OP_BIT_PROBE, 2'd0, 4'(n), 16'h0, 16'h7874);
      chk("prb", {carry_we, 10'h000, wb_en, carry_flag}, m);
    end
  endtask
  task t_seg;
    run(WBM_OP_SEVEN_SEGMENT, 2'd0, 4'h0, 16'h8765, 16'h1234);
    chk("seg", wb_data0, 16'h126D);
    run(WBM_OP_SEVEN_SEGMENT, 2'd0, 4'h0, 16'h8765, 16'hC3B4);
    chk("seg_dp", wb_data0, 16'hC3ED);
  endtask
  task t_repeat;
    int c0;
    @(posedge clk);
    #1;
    c0 = n_done;
    seq.issue(WBM_OP_BIT_TOGGLE, 2'd0, 4'h2, 16'h0, 16'h0, 64'h0, 3);
    @(posedge clk);
    #1;
    chk("repeat", 16'(n_done - c0), 16'd3);
  endtask
  task t_error;
    run(9'h003, 2'd0, 4'h0, 16'h0, 16'h0);
    chk("err", {op_done, op_error, carry_we, 9'h0, wb_en}, 16'hC000);
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_encode();
    t_decode();
    t_split();
    t_combine();
    t_bits();
    t_seg();
    t_repeat();
    t_error();
    close_out();
  end
  initial begin
    #100000;
    fails++;
    close_out();
  end
endmodule
